// file: pkg/msfc_pkg.sv
package msfc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LIN_FILT = 8'h20;
  localparam logic [7:0] IDX_LIN_RR = 8'h21;
  localparam logic [7:0] IDX_LIN_CUT = 8'h22;
  localparam logic [7:0] IDX_ANG_FILT = 8'h23;
  localparam logic [7:0] IDX_ANG_RR = 8'h24;
  localparam logic [7:0] IDX_ANG_CUT = 8'h25;

  localparam int NUM_REGS = 6;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [2:0] SLOT_LIN_FILT = 3'h0;
  localparam logic [2:0] SLOT_LIN_RR = 3'h1;
  localparam logic [2:0] SLOT_LIN_CUT = 3'h2;
  localparam logic [2:0] SLOT_ANG_FILT = 3'h3;
  localparam logic [2:0] SLOT_ANG_RR = 3'h4;
  localparam logic [2:0] SLOT_ANG_CUT = 3'h5;

  localparam logic [5:0][7:0] REG_IDX = {IDX_ANG_CUT, IDX_ANG_RR, IDX_ANG_FILT,
                                         IDX_LIN_CUT, IDX_LIN_RR, IDX_LIN_FILT};
  // reserved bits are not stored and read as zero
  localparam logic [5:0][7:0] REG_MASK = {8'h0F, 8'h7F, 8'h03, 8'h0F, 8'h7F, 8'h83};
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_WATCH = 7;
  localparam int BIT_BYPASS = 1;
  localparam int BIT_FILT = 0;
  localparam int RANGE_LSB = 4;
  localparam int RATE_LSB = 0;

  // watch mode keeps one sample in this many
  localparam int WATCH_DIV = 1520;
  localparam logic [10:0] WATCH_LAST = 11'(WATCH_DIV - 1);

  // ----------------------------------------------------------------
  // decode tables, zero marks a reserved code
  // ----------------------------------------------------------------
  localparam logic [7:0][10:0] LIN_RANGE_G = {11'h000, 11'h000, 11'h000, 11'h020,
                                              11'h010, 11'h008, 11'h004, 11'h002};
  localparam logic [7:0][10:0] ANG_RANGE_DPS = {11'h000, 11'h7D0, 11'h3E8, 11'h1F4,
                                                11'h0FA, 11'h07D, 11'h03E, 11'h01F};
  localparam logic [15:0][13:0] LIN_RATE_HZ = {14'h0000, 14'h0000, 14'h0000, 14'h0000,
                                               14'h0000, 14'h1F40, 14'h0FA0, 14'h07D0,
                                               14'h0000, 14'h0000, 14'h0000, 14'h0000,
                                               14'h007D, 14'h00FA, 14'h01F4, 14'h03E8};
  localparam logic [15:0][13:0] ANG_RATE_HZ = {14'h0000, 14'h0000, 14'h0000, 14'h0000,
                                               14'h3E80, 14'h1F40, 14'h0FA0, 14'h07D0,
                                               14'h0000, 14'h0000, 14'h0000, 14'h0000,
                                               14'h007D, 14'h00FA, 14'h01F4, 14'h03E8};
  // cutoff factor in hundredths
  localparam logic [15:0][5:0] CUT_N_X100 = {6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08,
                                             6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h14, 6'h18,
                                             6'h1C, 6'h20, 6'h24, 6'h28};

  typedef struct packed {
    logic filt_en;
    logic lpf_bypass;
    logic range_rsvd;
    logic rate_rsvd;
    logic [10:0] range_val;
    logic [13:0] rate_hz;
    logic [19:0] cutoff_x100;
  } msfc_path_type;

endpackage

// file: logic/msfc_path_decode.sv
`timescale 1ns/1ps
module msfc_path_decode
#(
  parameter bit ANGULAR = 1'b0
)
(
  // stored configuration
  input wire logic [7:0] filt_reg,
  input wire logic [7:0] rr_reg,
  input wire logic [7:0] cut_reg,
  // decoded path settings
  output msfc_pkg::msfc_path_type path
);

  wire [2:0] range_code = rr_reg[msfc_pkg::RANGE_LSB +: 3];
  wire [3:0] rate_code = rr_reg[msfc_pkg::RATE_LSB +: 4];
  wire [3:0] cut_code = cut_reg[3:0];
  wire [10:0] range_val;
  wire [13:0] rate_hz;
  wire [5:0] n_x100;

  assign range_val = ANGULAR ? msfc_pkg::ANG_RANGE_DPS[range_code]
                             : msfc_pkg::LIN_RANGE_G[range_code];
  assign rate_hz = ANGULAR ? msfc_pkg::ANG_RATE_HZ[rate_code]
                           : msfc_pkg::LIN_RATE_HZ[rate_code];
  assign n_x100 = msfc_pkg::CUT_N_X100[cut_code];

  assign path.filt_en = filt_reg[msfc_pkg::BIT_FILT];
  assign path.lpf_bypass = filt_reg[msfc_pkg::BIT_BYPASS];
  assign path.range_rsvd = (range_val == 11'h000);
  assign path.rate_rsvd = (rate_hz == 14'h0000);
  assign path.range_val = range_val;
  assign path.rate_hz = rate_hz;
  // follows any rate change with the stored factor code
  assign path.cutoff_x100 = 20'(rate_hz) * 20'(n_x100);

endmodule

// file: logic/msfc_top.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module msfc_top
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // linear sample stream
  input wire logic acc_sample_valid,
  output logic acc_sample_keep,
  // decoded path settings
  output logic lin_watch_en,
  output msfc_pkg::msfc_path_type lin_path,
  output msfc_pkg::msfc_path_type ang_path
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    logic [2:0] slot;
    slot = msfc_pkg::SLOT_NONE;
    for (int i = 0; i < msfc_pkg::NUM_REGS; i++)
    begin
      if (addr == {22'h000000, msfc_pkg::REG_IDX[i], 2'b00})
      begin
        slot = 3'(i);
      end
    end
    return slot;
  endfunction

  logic dp_valid_ff;
  logic dp_write_ff;
  logic [2:0] dp_slot_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic [7:0] regs_ff [msfc_pkg::NUM_REGS];

  wire ap_take = hsel && htrans[1] && hready;
  wire [2:0] ap_slot = slot_of(haddr);
  wire wr_now = dp_valid_ff && dp_write_ff && (dp_slot_ff != msfc_pkg::SLOT_NONE);
  wire [7:0] wr_byte = hwdata[7:0] & msfc_pkg::REG_MASK[dp_slot_ff];
  // a read right behind a write to the same register sees the new value
  wire fwd_hit = wr_now && (dp_slot_ff == ap_slot);
  wire [7:0] rd_byte = (ap_slot == msfc_pkg::SLOT_NONE) ? 8'h00 :
                       fwd_hit ? wr_byte : regs_ff[ap_slot];
  wire [31:0] nxt_hrdata = (ap_take && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_slot_ff <= msfc_pkg::SLOT_NONE;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b0;
    end
    else
    begin
      dp_valid_ff <= ap_take;
      dp_write_ff <= hwrite;
      dp_slot_ff <= ap_slot;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  // every transfer completes OKAY, unmapped ones included
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < msfc_pkg::NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          regs_ff[gi] <= msfc_pkg::REG_RESET;
        end
        else if (wr_now && (dp_slot_ff == 3'(gi)))
        begin
          regs_ff[gi] <= wr_byte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // path decode
  // ----------------------------------------------------------------
  msfc_pkg::msfc_path_type lin_dec;
  msfc_pkg::msfc_path_type ang_dec;
  msfc_pkg::msfc_path_type lin_path_ff;
  msfc_pkg::msfc_path_type ang_path_ff;
  logic lin_watch_ff;

  msfc_path_decode #(.ANGULAR(1'b0)) u_lin_dec
  (
    .filt_reg(regs_ff[msfc_pkg::SLOT_LIN_FILT]),
    .rr_reg(regs_ff[msfc_pkg::SLOT_LIN_RR]),
    .cut_reg(regs_ff[msfc_pkg::SLOT_LIN_CUT]),
    .path(lin_dec)
  );

  msfc_path_decode #(.ANGULAR(1'b1)) u_ang_dec
  (
    .filt_reg(regs_ff[msfc_pkg::SLOT_ANG_FILT]),
    .rr_reg(regs_ff[msfc_pkg::SLOT_ANG_RR]),
    .cut_reg(regs_ff[msfc_pkg::SLOT_ANG_CUT]),
    .path(ang_dec)
  );

  wire nxt_watch = regs_ff[msfc_pkg::SLOT_LIN_FILT][msfc_pkg::BIT_WATCH];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lin_path_ff <= '0;
      ang_path_ff <= '0;
      lin_watch_ff <= 1'b0;
    end
    else
    begin
      lin_path_ff <= lin_dec;
      ang_path_ff <= ang_dec;
      lin_watch_ff <= nxt_watch;
    end
  end

  assign lin_path = lin_path_ff;
  assign ang_path = ang_path_ff;
  assign lin_watch_en = lin_watch_ff;

  // ----------------------------------------------------------------
  // watch-mode decimation
  // ----------------------------------------------------------------
  // counter restarts whenever watch is off, so the first sample after
  // enabling always passes
  logic [10:0] dec_cnt_ff;
  logic keep_ff;

  wire cnt_wrap = (dec_cnt_ff == msfc_pkg::WATCH_LAST);
  wire [10:0] nxt_dec_cnt = !lin_watch_ff ? 11'h000 :
                            !acc_sample_valid ? dec_cnt_ff :
                            cnt_wrap ? 11'h000 : dec_cnt_ff + 11'h001;
  wire nxt_keep = acc_sample_valid && (!lin_watch_ff || (dec_cnt_ff == 11'h000));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dec_cnt_ff <= 11'h000;
      keep_ff <= 1'b0;
    end
    else
    begin
      dec_cnt_ff <= nxt_dec_cnt;
      keep_ff <= nxt_keep;
    end
  end

  assign acc_sample_keep = keep_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wr_lin_filt;
    wr_now && (dp_slot_ff == msfc_pkg::SLOT_LIN_FILT);
  endsequence

  sequence s_wr_ang_filt;
    wr_now && (dp_slot_ff == msfc_pkg::SLOT_ANG_FILT);
  endsequence

  a_watch_gap_drop: assert property (
    lin_watch_ff && acc_sample_valid && (dec_cnt_ff != 11'h000) ##1 lin_watch_ff
    |-> !keep_ff)
    else $error("watch mode passed a sample off the 1520 grid");

  a_watch_off_pass: assert property (
    !lin_watch_ff && acc_sample_valid |=> keep_ff)
    else $error("sample dropped with watch mode off");

  a_watch_cnt_wrap: assert property (
    lin_watch_ff && acc_sample_valid && (dec_cnt_ff == msfc_pkg::WATCH_LAST) ##1 lin_watch_ff
    |-> (dec_cnt_ff == 11'h000))
    else $error("watch counter did not wrap at 1520");

  a_lin_bypass_wr: assert property (
    s_wr_lin_filt |-> ##2 (lin_path.lpf_bypass == $past(hwdata[1], 2)))
    else $error("linear bypass does not follow written bit");

  a_lin_filt_wr: assert property (
    s_wr_lin_filt |-> ##2 (lin_path.filt_en == $past(hwdata[0], 2)))
    else $error("linear filter enable does not follow written bit");

  a_lin_range_top: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][6:4] == 3'h4) |=>
    (lin_path.range_val == 11'h020) && !lin_path.range_rsvd)
    else $error("linear range code 4 is not 32g");

  a_lin_range_rsvd: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][6:4] > 3'h4) |=> lin_path.range_rsvd)
    else $error("reserved linear range not flagged");

  a_lin_rate_max: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][3:0] == 4'hA) |=> (lin_path.rate_hz == 14'h1F40))
    else $error("linear rate code 1010 is not 8000 Hz");

  a_lin_rate_rsvd: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][3:0] == 4'hB) |=> lin_path.rate_rsvd)
    else $error("linear rate code 1011 not reserved");

  a_lin_cut_min: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][3:0] == 4'h0) &&
    (regs_ff[msfc_pkg::SLOT_LIN_CUT][3:0] == 4'hF) |=> (lin_path.cutoff_x100 == 20'h003E8))
    else $error("linear cutoff 1000 Hz times 0.01 wrong");

  a_ang_bypass_wr: assert property (
    s_wr_ang_filt |-> ##2 (ang_path.lpf_bypass == $past(hwdata[1], 2)))
    else $error("angular bypass does not follow written bit");

  a_ang_filt_wr: assert property (
    s_wr_ang_filt |-> ##2 (ang_path.filt_en == $past(hwdata[0], 2)))
    else $error("angular filter enable does not follow written bit");

  a_ang_range_top: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][6:4] == 3'h6) |=> (ang_path.range_val == 11'h7D0))
    else $error("angular range code 6 is not 2000 dps");

  a_ang_rate_max: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][3:0] == 4'hB) |=> (ang_path.rate_hz == 14'h3E80))
    else $error("angular rate code 1011 is not 16000 Hz");

  a_ang_cut_max: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][3:0] == 4'hB) &&
    (regs_ff[msfc_pkg::SLOT_ANG_CUT][3:0] == 4'h0) |=> (ang_path.cutoff_x100 == 20'h9C400))
    else $error("angular cutoff 16000 Hz times 0.40 wrong");

  a_rate_cut_track: assert property (
    $changed(lin_path.rate_hz) && $stable(regs_ff[msfc_pkg::SLOT_LIN_CUT]) |->
    (lin_path.cutoff_x100 == 20'(lin_path.rate_hz) *
     20'(msfc_pkg::CUT_N_X100[regs_ff[msfc_pkg::SLOT_LIN_CUT][3:0]])))
    else $error("cutoff not recomputed on rate change");

  a_rd_unmapped: assert property (
    ap_take && !hwrite && (ap_slot == msfc_pkg::SLOT_NONE) |=> (hrdata == 32'h00000000))
    else $error("unmapped read returned nonzero");

  a_ang_rate_track: assert property (
    $changed(ang_path.rate_hz) && $stable(regs_ff[msfc_pkg::SLOT_ANG_CUT]) |->
    (ang_path.cutoff_x100 == 20'(ang_path.rate_hz) *
     20'(msfc_pkg::CUT_N_X100[regs_ff[msfc_pkg::SLOT_ANG_CUT][3:0]])))
    else $error("angular cutoff not recomputed on rate change");

  a_lin_range_low: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][6:4] == 3'h0) |=> (lin_path.range_val == 11'h002))
    else $error("linear range code 0 is not 2g");

  a_ang_range_low: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][6:4] == 3'h0) |=> (ang_path.range_val == 11'h01F))
    else $error("angular range code 0 is not 31 dps");

  a_ang_range_rsvd: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][6:4] == 3'h7) |=> ang_path.range_rsvd)
    else $error("reserved angular range not flagged");

  a_lin_rate_low: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][3:0] == 4'h3) |=> (lin_path.rate_hz == 14'h007D))
    else $error("linear rate code 0011 is not 125 Hz");

  a_ang_rate_low: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][3:0] == 4'h3) |=> (ang_path.rate_hz == 14'h007D))
    else $error("angular rate code 0011 is not 125 Hz");

  a_ang_rate_rsvd: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][3:0] == 4'hC) |=>
    ang_path.rate_rsvd && (ang_path.rate_hz == 14'h0000))
    else $error("angular rate code 1100 not reserved");

  a_lin_cut_top: assert property (
    (regs_ff[msfc_pkg::SLOT_LIN_RR][3:0] == 4'h0) &&
    (regs_ff[msfc_pkg::SLOT_LIN_CUT][3:0] == 4'h0) |=> (lin_path.cutoff_x100 == 20'h09C40))
    else $error("linear cutoff 1000 Hz times 0.40 wrong");

  a_ang_cut_min: assert property (
    (regs_ff[msfc_pkg::SLOT_ANG_RR][3:0] == 4'h0) &&
    (regs_ff[msfc_pkg::SLOT_ANG_CUT][3:0] == 4'hF) |=> (ang_path.cutoff_x100 == 20'h003E8))
    else $error("angular cutoff 1000 Hz times 0.01 wrong");

  // counter must sit at zero while watch is off, or enabling would
  // start mid-group and lose the first sample
  a_watch_cnt_clear: assert property (
    !lin_watch_ff |=> (dec_cnt_ff == 11'h000))
    else $error("watch counter not cleared while off");

  a_watch_cnt_hold: assert property (
    lin_watch_ff && !acc_sample_valid |=> $stable(dec_cnt_ff))
    else $error("watch counter moved without a sample");

  a_keep_after_valid: assert property (
    keep_ff |-> $past(acc_sample_valid))
    else $error("sample kept without a valid input");

  a_watch_level: assert property (
    regs_ff[msfc_pkg::SLOT_LIN_FILT][msfc_pkg::BIT_WATCH] |=> lin_watch_en)
    else $error("watch level does not follow control bit");

  a_rd_data_idle: assert property (
    !(ap_take && !hwrite) |=> (hrdata == 32'h00000000))
    else $error("read data not cleared outside read data phase");

  a_ready_high: assert property (
    hresetn |=> hreadyout)
    else $error("slave inserted a wait state");

endmodule

// file: bench/msfc_top_tb.sv
`timescale 1ns/1ps
module msfc_top_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic acc_sample_valid;
  logic acc_sample_keep;
  logic lin_watch_en;
  msfc_pkg::msfc_path_type lin_path;
  msfc_pkg::msfc_path_type ang_path;
  int n_mismatch;
  int cmp_count;
  // zero marks a reserved code
  int lin_g[8] = '{2, 4, 8, 16, 32, 0, 0, 0};
  int ang_dps[8] = '{31, 62, 125, 250, 500, 1000, 2000, 0};
  int rate_tab[16] = '{1000, 500, 250, 125, 0, 0, 0, 0, 2000, 4000, 8000, 0, 0, 0, 0, 0};
  int n_x100[16] = '{40, 36, 32, 28, 24, 20, 16, 14, 12, 10, 8, 6, 4, 3, 2, 1};

  msfc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acc_sample_valid(acc_sample_valid), .acc_sample_keep(acc_sample_keep),
    .lin_watch_en(lin_watch_en), .lin_path(lin_path), .ang_path(ang_path));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk_path(input msfc_pkg::msfc_path_type got, input msfc_pkg::msfc_path_type exp,
                input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic msfc_pkg::msfc_path_type exp_path(input logic [7:0] f,
      input logic [7:0] rr, input logic [7:0] c, input bit ang);
    msfc_pkg::msfc_path_type p;
    int rng;
    int rate;
    rng = ang ? ang_dps[rr[6:4]] : lin_g[rr[6:4]];
    rate = (ang && rr[3:0] == 4'hB) ? 16000 : rate_tab[rr[3:0]];
    p.filt_en = f[0];
    p.lpf_bypass = f[1];
    p.range_rsvd = (rng == 0);
    p.rate_rsvd = (rate == 0);
    p.range_val = 11'(rng);
    p.rate_hz = 14'(rate);
    p.cutoff_x100 = 20'(rate * n_x100[c[3:0]]);
    return p;
  endfunction

  // ----------------------------------------------------------------
  // bus master, entered and left just after a rising edge
  // ----------------------------------------------------------------
  task wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        n_mismatch++;
        $display("unexpected at %0t: bus wait ran out", $time);
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task bus_xfer(input logic [31:0] a, input logic w, input logic [7:0] d,
                output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_ready();
    r = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus_xfer(a, 1'b1, d, r);
  endtask

  task rd_chk(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] r;
    bus_xfer(a, 1'b0, 8'h00, r);
    chk_val(r, {24'h000000, exp}, "register read");
  endtask

  // decoded outputs land one edge after the register
  task settle();
    repeat (2) @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_reset();
    for (int a = 32'h80; a <= 32'h94; a += 4)
      rd_chk(a, 8'h00);
    chk_path(lin_path, exp_path(8'h00, 8'h00, 8'h00, 0), "linear reset");
    chk_path(ang_path, exp_path(8'h00, 8'h00, 8'h00, 1), "angular reset");
    chk_val({31'h0, hresp}, 32'h00000000, "response");
    $display("test reset done");
  endtask

  task test_filter_bits();
    wr(32'h80, 8'hFF);
    wr(32'h8C, 8'hFF);
    rd_chk(32'h80, 8'h83);
    rd_chk(32'h8C, 8'h03);
    settle();
    chk_val({31'h0, lin_watch_en}, 32'h00000001, "watch level");
    chk_path(lin_path, exp_path(8'h83, 8'h00, 8'h00, 0), "linear bits");
    chk_path(ang_path, exp_path(8'h03, 8'h00, 8'h00, 1), "angular bits");
    $display("test filter bits done");
  endtask

  // every range, rate and factor code on both paths; rate written last
  task test_decode();
    logic [7:0] f;
    logic [7:0] rr;
    logic [7:0] c;
    for (int i = 0; i < 16; i++)
    begin
      f = {i[3], 5'h15, i[1:0]};
      c = {4'hA, 4'(15 - i)};
      rr = {i[0], i[2:0], i[3:0]};
      wr(32'h80, f);
      wr(32'h88, c);
      wr(32'h84, rr);
      wr(32'h8C, f);
      wr(32'h94, c);
      wr(32'h90, rr);
      rd_chk(32'h84, rr & 8'h7F);
      rd_chk(32'h88, c & 8'h0F);
      rd_chk(32'h90, rr & 8'h7F);
      rd_chk(32'h94, c & 8'h0F);
      settle();
      chk_path(lin_path, exp_path(f, rr, c, 0), "linear decode");
      chk_path(ang_path, exp_path(f, rr, c, 1), "angular decode");
    end
    // rates moved alone must pick up the factors already stored
    wr(32'h94, 8'h00);
    wr(32'h90, 8'h6B);
    wr(32'h84, 8'h4A);
    settle();
    chk_path(ang_path, exp_path(8'h03, 8'h6B, 8'h00, 1), "angular top");
    chk_path(lin_path, exp_path(8'h83, 8'h4A, 8'h00, 0), "linear top");
    $display("test decode done");
  endtask

  task test_unmapped();
    wr(32'h88, 8'h05);
    wr(32'h08, 8'hFF);
    wr(32'h98, 8'hFF);
    rd_chk(32'h88, 8'h05);
    rd_chk(32'h08, 8'h00);
    rd_chk(32'h98, 8'h00);
    $display("test unmapped done");
  endtask

  task send_samples(input int n, output int keeps);
    keeps = 0;
    for (int j = 0; j < n + 2; j++)
    begin
      acc_sample_valid <= (j < n);
      @(posedge hclk);
      if (acc_sample_keep === 1'b1)
        keeps++;
    end
  endtask

  // the group count restarts whenever watch mode is switched off
  task test_watch(input logic [7:0] ctl, input int n, input int exp);
    int keeps;
    wr(32'h80, ctl);
    settle();
    chk_val({31'h0, lin_watch_en}, {31'h0, ctl[7]}, "watch level");
    send_samples(n, keeps);
    chk_val(keeps, exp, "kept samples");
    wr(32'h80, 8'h00);
    settle();
    $display("test watch %0d samples done", n);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    acc_sample_valid = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    @(posedge hclk);
    test_reset();
    test_filter_bits();
    test_decode();
    test_unmapped();
    test_watch(8'h00, 5, 5);
    test_watch(8'h80, 3040, 2);
    test_watch(8'h80, 3041, 3);
    end_of_test();
  end
endmodule
